// *** logic_delay_timer.sv ***
`timescale 1ns/1ns
module logic_delay_timer import logic_timer_pkg::*; #(
  parameter int W = DLY_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clr,
  input wire logic i_tick,
  input wire logic i_in,
  input wire logic [W-1:0] i_pu,
  input wire logic [W-1:0] i_do,
  output logic o_out
);

  typedef struct packed {
    logic out;
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t st_ff;
  tmr_t nxt_st;

  // ----------------------------------------------------------------
  // Pickup and dropout
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (i_tick) begin
      if (i_in == st_ff.out) begin
        nxt_st.cnt = '0;
      end else if (st_ff.cnt >= (st_ff.out ? i_do : i_pu)) begin
        nxt_st.out = i_in;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = W'(st_ff.cnt + 1'b1);
      end
    end
    // Clear or reset zeroes the count and drops the output
    if (i_clr || i_sys_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st_ff <= nxt_st;
  end

  assign o_out = st_ff.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_no_early;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_tick && !st_ff.out && st_ff.cnt < i_pu && !i_clr |=> !st_ff.out;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("timed output rose before pickup delay");

  property p_drop_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_tick && st_ff.out && !i_in && st_ff.cnt < i_do && !i_clr |=> st_ff.out;
  endproperty
  a_drop_hold: assert property (p_drop_hold)
    else $error("timed output fell before dropout delay");

  property p_steady_in;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_tick && !i_in && !st_ff.out |=> !st_ff.out && st_ff.cnt == '0;
  endproperty
  a_steady_in: assert property (p_steady_in)
    else $error("pickup count kept after input dropped");

endmodule

// *** logic_timer_output_driver.sv ***
`timescale 1ns/1ns
module logic_timer_output_driver import logic_timer_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int PULSE_TICKS = PULSE_TICKS_DFLT
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_settings_reset,
  input wire logic [15:0] i_relay_bits,
  input wire logic i_access_lvl2,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [NUM_OUTS-1:0] o_coil,
  output logic [NUM_OUTS-1:0] o_contact_closed,
  output logic o_alarm_coil,
  output logic o_alarm_bit,
  output logic o_alarm_closed,
  output logic [NUM_VARS-1:0] o_logic_var,
  output logic [NUM_VARS-1:0] o_timed_out,
  output logic o_irq
);

  typedef struct packed {
    logic [15:0] tick_cnt;
    logic tick;
    logic [NUM_VARS-1:0][SRC_W-1:0] set_mask;
    logic [NUM_VARS-1:0][SRC_W-1:0] hold_mask;
    logic [NUM_VARS-1:0][DLY_W-1:0] pu;
    logic [NUM_VARS-1:0][DLY_W-1:0] dly_do;
    logic [NUM_VARS-1:0] self_en;
    logic [NUM_VARS-1:0] lv;
    logic [NUM_OUTS-1:0][5:0] out_sel;
    logic [NUM_OUTS:0] ctype;
    logic [NUM_OUTS-1:0] coil;
    logic lvl2_q;
    logic [NUM_VARS-1:0] timed_q;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [SRC_W-1:0] src;
  logic [NUM_VARS-1:0] lv_new;
  logic [NUM_VARS-1:0] timed;
  logic [NUM_OUTS-1:0] eq_out;
  logic [NUM_OUTS-1:0] pulse_act;
  logic [NUM_OUTS-1:0] pulse_start;
  logic alarm_act;
  logic alarm_start;
  logic lvl2_rise;
  logic wr_pulse;
  logic [IRQ_W-1:0] irq_ev;
  logic [3:0] widx;

  // ----------------------------------------------------------------
  // Delay clamp
  // ----------------------------------------------------------------
  function automatic logic [DLY_W-1:0] clamp_dly(
    input logic [31:0] v,
    input logic long_tmr
  );
    logic [31:0] lim;
    lim = long_tmr ? LONG_MAX_QTR : SHORT_MAX_QTR;
    // Out of range settings saturate rather than wrap
    return (v > lim) ? lim[DLY_W-1:0] : v[DLY_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Equations and timers
  // ----------------------------------------------------------------
  assign src = {timed, i_relay_bits};

  for (genvar n = 0; n < NUM_VARS; n++) begin : g_var
    logic set_hit;
    logic hold_ok;
    assign set_hit = |(src & st_ff.set_mask[n]);
    // Empty qualifier mask means no qualifier term
    assign hold_ok = (st_ff.hold_mask[n] == '0) ||
      (|(src & st_ff.hold_mask[n]));
    assign lv_new[n] =
      ((st_ff.self_en[n] & st_ff.lv[n]) | set_hit) & hold_ok;
    logic_delay_timer #(
      .W(DLY_W)
    ) u_tmr (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_clr(i_settings_reset),
      .i_tick(st_ff.tick),
      .i_in(lv_new[n]),
      .i_pu(st_ff.pu[n]),
      .i_do(st_ff.dly_do[n]),
      .o_out(timed[n])
    );
  end

  // ----------------------------------------------------------------
  // Output bits and pulses
  // ----------------------------------------------------------------
  assign wr_pulse = i_wr && (i_addr == A_PULSE);
  assign pulse_start = wr_pulse ? i_wdata[NUM_OUTS-1:0] : '0;
  assign lvl2_rise = i_access_lvl2 && !st_ff.lvl2_q;
  assign alarm_start =
    (wr_pulse && i_wdata[ALARM_PULSE_BIT]) || lvl2_rise;

  for (genvar m = 0; m < NUM_OUTS; m++) begin : g_out
    assign eq_out[m] = st_ff.out_sel[m][OUT_EN_BIT] &
      src[st_ff.out_sel[m][4:0]];
    momentary_pulse #(
      .TICKS(PULSE_TICKS)
    ) u_pls (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_start(pulse_start[m]),
      .i_tick(st_ff.tick),
      .o_active(pulse_act[m])
    );
  end

  momentary_pulse #(
    .TICKS(PULSE_TICKS)
  ) u_alarm (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_start(alarm_start),
    .i_tick(st_ff.tick),
    .o_active(alarm_act)
  );

  assign irq_ev = {alarm_start, timed & ~st_ff.timed_q};
  assign widx = i_addr[3:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    if (st_ff.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = 16'h0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = 16'(st_ff.tick_cnt + 16'h0001);
    end
    if (st_ff.tick) begin
      nxt_st.lv = lv_new;
      nxt_st.coil = eq_out | pulse_act;
    end
    if (i_settings_reset) begin
      nxt_st.lv = '0;
    end
    nxt_st.lvl2_q = i_access_lvl2;
    nxt_st.timed_q = timed;
    // Set wins over a clear in the same cycle
    nxt_st.irq_st = st_ff.irq_st | irq_ev;
    if (i_wr) begin
      case (i_addr[7:4])
        G_SET: begin
          nxt_st.set_mask[widx] = i_wdata;
        end
        G_HOLD: begin
          nxt_st.hold_mask[widx] = i_wdata;
        end
        G_PU: begin
          nxt_st.pu[widx] =
            clamp_dly(i_wdata, 32'(widx) < NUM_LONG);
        end
        G_DO: begin
          nxt_st.dly_do[widx] =
            clamp_dly(i_wdata, 32'(widx) < NUM_LONG);
        end
        G_OUT: begin
          if (32'(widx) < NUM_OUTS) begin
            nxt_st.out_sel[widx[2:0]] = i_wdata[5:0];
          end
        end
        G_MISC: begin
          case (i_addr)
            A_SELF: nxt_st.self_en = i_wdata[NUM_VARS-1:0];
            A_CTYPE: nxt_st.ctype = i_wdata[NUM_OUTS:0];
            A_IRQ_CLR: begin
              nxt_st.irq_st = (st_ff.irq_st & ~i_wdata[IRQ_W-1:0]) | irq_ev;
            end
            A_IRQ_EN: nxt_st.irq_en = i_wdata[IRQ_W-1:0];
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr[7:4])
        G_SET: nxt_st.rdata = st_ff.set_mask[widx];
        G_HOLD: nxt_st.rdata = st_ff.hold_mask[widx];
        G_PU: nxt_st.rdata = 32'(st_ff.pu[widx]);
        G_DO: nxt_st.rdata = 32'(st_ff.dly_do[widx]);
        G_OUT: begin
          if (32'(widx) < NUM_OUTS) begin
            nxt_st.rdata = 32'(st_ff.out_sel[widx[2:0]]);
          end
        end
        G_MISC: begin
          case (i_addr)
            A_SELF: nxt_st.rdata = 32'(st_ff.self_en);
            A_CTYPE: nxt_st.rdata = 32'(st_ff.ctype);
            A_STATE: nxt_st.rdata = {timed, st_ff.lv};
            A_COIL: begin
              nxt_st.rdata = {8'h00, o_alarm_closed, o_contact_closed,
                7'h00, alarm_act, o_alarm_coil, st_ff.coil};
            end
            A_IRQ_ST: nxt_st.rdata = 32'(st_ff.irq_st);
            A_IRQ_EN: nxt_st.rdata = 32'(st_ff.irq_en);
            default: nxt_st.rdata = 32'h0000_0000;
          endcase
        end
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    if (i_sys_rst) begin
      nxt_st = '0;
      nxt_st.set_mask[0] = DFLT_SET_MASK;
      nxt_st.pu[0] = DFLT_PU;
      nxt_st.dly_do[0] = DFLT_DO;
      nxt_st.out_sel[0] = DFLT_OUT_TRIP;
      nxt_st.out_sel[1] = DFLT_OUT_CLOSE;
      nxt_st.out_sel[2] = DFLT_OUT_TMR1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = st_ff.rdata;
  assign o_coil = st_ff.coil;
  assign o_contact_closed = st_ff.coil ^ st_ff.ctype[NUM_OUTS-1:0];
  assign o_alarm_coil = ~alarm_act;
  assign o_alarm_bit = alarm_act;
  assign o_alarm_closed = ~alarm_act ^ st_ff.ctype[NUM_OUTS];
  assign o_logic_var = st_ff.lv;
  assign o_timed_out = timed;
  assign o_irq = |(st_ff.irq_st & st_ff.irq_en);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_tick_now;
    st_ff.tick;
  endsequence

  sequence s_coils_follow;
    ##1 (o_coil == $past(eq_out | pulse_act));
  endsequence

  property p_coil_update;
    s_tick_now |-> s_coils_follow;
  endproperty
  a_coil_update: assert property (p_coil_update)
    else $error("coils did not follow output bits at interval");

  property p_eq_drives;
    st_ff.tick && (eq_out != '0) |=>
      ((o_coil & $past(eq_out)) == $past(eq_out));
  endproperty
  a_eq_drives: assert property (p_eq_drives)
    else $error("true equation did not set output bit");

  property p_zero_quiet;
    st_ff.tick |=> ((o_coil & ~$past(eq_out | pulse_act)) == '0);
  endproperty
  a_zero_quiet: assert property (p_zero_quiet)
    else $error("output energized without equation or pulse");

  sequence s_pulse_cmd;
    wr_pulse && (i_wdata[NUM_OUTS-1:0] != '0);
  endsequence

  property p_pulse_arm;
    s_pulse_cmd |=>
      ((pulse_act & $past(i_wdata[NUM_OUTS-1:0])) ==
       $past(i_wdata[NUM_OUTS-1:0]));
  endproperty
  a_pulse_arm: assert property (p_pulse_arm)
    else $error("pulse command did not arm output pulse");

  property p_pulse_out;
    st_ff.tick && (pulse_act != '0) |=>
      ((o_coil & $past(pulse_act)) == $past(pulse_act));
  endproperty
  a_pulse_out: assert property (p_pulse_out)
    else $error("pulsed output bit not asserted");

  property p_ctype_write;
    i_wr && (i_addr == A_CTYPE) |=>
      (o_contact_closed == (o_coil ^ $past(i_wdata[NUM_OUTS-1:0])));
  endproperty
  a_ctype_write: assert property (p_ctype_write)
    else $error("contact state does not match written type");

  property p_alarm_held;
    !alarm_start && !alarm_act |=> !o_alarm_bit && o_alarm_coil;
  endproperty
  a_alarm_held: assert property (p_alarm_held)
    else $error("alarm moved without a cause");

  property p_alarm_cmd;
    wr_pulse && i_wdata[ALARM_PULSE_BIT] |=> o_alarm_bit && !o_alarm_coil;
  endproperty
  a_alarm_cmd: assert property (p_alarm_cmd)
    else $error("alarm pulse command ignored");

  property p_lvl2;
    i_access_lvl2 && !st_ff.lvl2_q |=> o_alarm_bit && !o_alarm_coil;
  endproperty
  a_lvl2: assert property (p_lvl2)
    else $error("access level entry did not pulse alarm");

  property p_settings_clear;
    i_settings_reset |=> (o_logic_var == '0) && (o_timed_out == '0);
  endproperty
  a_settings_clear: assert property (p_settings_clear)
    else $error("settings reset left variables set");

  property p_latch_broken;
    i_settings_reset ##1 (st_ff.tick && !i_settings_reset &&
      (g_var[6].set_hit == 1'b0)) |=> !o_logic_var[6];
  endproperty
  a_latch_broken: assert property (p_latch_broken)
    else $error("self latch survived reset");

  property p_self_hold;
    st_ff.tick && !i_settings_reset && st_ff.self_en[6] &&
      st_ff.lv[6] && g_var[6].hold_ok |=> o_logic_var[6];
  endproperty
  a_self_hold: assert property (p_self_hold)
    else $error("self latch dropped while qualifier true");

  property p_eval_on_tick;
    !st_ff.tick && !i_settings_reset |=>
      (o_logic_var == $past(o_logic_var));
  endproperty
  a_eval_on_tick: assert property (p_eval_on_tick)
    else $error("variables changed between intervals");

endmodule

// *** logic_timer_pkg.sv ***
package logic_timer_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_VARS = 16;
  localparam int NUM_LONG = 6;
  localparam int NUM_OUTS = 7;
  localparam int DLY_W = 22;
  localparam int SRC_W = 32;
  localparam int IRQ_W = 17;
  localparam int IRQ_ALARM_BIT = 16;
  localparam int ALARM_PULSE_BIT = 7;
  localparam int OUT_EN_BIT = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int LINE_HZ = 60;
  localparam int QTR_PER_CYCLE = 4;
  localparam int TICK_CYCLES_DFLT = SYS_CLK_HZ / (LINE_HZ * QTR_PER_CYCLE);
  localparam int PULSE_TICKS_DFLT = 4;
  localparam int LONG_MAX_CYCLES = 999999;
  localparam int SHORT_MAX_CYCLES = 16000;
  localparam logic [31:0] LONG_MAX_QTR = 32'(LONG_MAX_CYCLES * QTR_PER_CYCLE);
  localparam logic [31:0] SHORT_MAX_QTR =
    32'(SHORT_MAX_CYCLES * QTR_PER_CYCLE);

  // ----------------------------------------------------------------
  // Sources and defaults
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_TRIP = 5'h00;
  localparam logic [4:0] SRC_CLOSE = 5'h01;
  localparam logic [4:0] SRC_TIMED_BASE = 5'h10;
  localparam int DFLT_PU_CYCLES = 12;
  localparam int DFLT_DO_CYCLES = 2;
  localparam logic [DLY_W-1:0] DFLT_PU =
    DLY_W'(DFLT_PU_CYCLES * QTR_PER_CYCLE);
  localparam logic [DLY_W-1:0] DFLT_DO =
    DLY_W'(DFLT_DO_CYCLES * QTR_PER_CYCLE);
  localparam logic [SRC_W-1:0] DFLT_SET_MASK = 32'h0000_0001;
  localparam logic [5:0] OUT_EN = 6'h20;
  localparam logic [5:0] DFLT_OUT_TRIP = OUT_EN | {1'b0, SRC_TRIP};
  localparam logic [5:0] DFLT_OUT_CLOSE = OUT_EN | {1'b0, SRC_CLOSE};
  localparam logic [5:0] DFLT_OUT_TMR1 = OUT_EN | {1'b0, SRC_TIMED_BASE};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] G_SET = 4'h0;
  localparam logic [3:0] G_HOLD = 4'h1;
  localparam logic [3:0] G_PU = 4'h2;
  localparam logic [3:0] G_DO = 4'h3;
  localparam logic [3:0] G_OUT = 4'h4;
  localparam logic [3:0] G_MISC = 4'h5;
  localparam logic [7:0] A_SELF = 8'h50;
  localparam logic [7:0] A_CTYPE = 8'h51;
  localparam logic [7:0] A_PULSE = 8'h52;
  localparam logic [7:0] A_STATE = 8'h53;
  localparam logic [7:0] A_COIL = 8'h54;
  localparam logic [7:0] A_IRQ_ST = 8'h55;
  localparam logic [7:0] A_IRQ_CLR = 8'h56;
  localparam logic [7:0] A_IRQ_EN = 8'h57;

endpackage

// *** momentary_pulse.sv ***
`timescale 1ns/1ns
module momentary_pulse import logic_timer_pkg::*; #(
  parameter int TICKS = PULSE_TICKS_DFLT
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic i_tick,
  output logic o_active
);

  typedef struct packed {
    logic active;
    logic [7:0] cnt;
  } pls_t;

  pls_t st_ff;
  pls_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.active && i_tick) begin
      if (st_ff.cnt <= 8'h01) begin
        nxt_st.active = 1'b0;
        nxt_st.cnt = 8'h00;
      end else begin
        nxt_st.cnt = 8'(st_ff.cnt - 8'h01);
      end
    end
    // A restart stretches the pulse
    if (i_start) begin
      nxt_st.active = 1'b1;
      nxt_st.cnt = 8'(TICKS);
    end
    if (i_sys_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st_ff <= nxt_st;
  end

  assign o_active = st_ff.active;

  property p_pulse_len;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_start |=> st_ff.active && st_ff.cnt == 8'(TICKS);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("momentary pulse not loaded with its length");

endmodule

// *** relay_field_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Field inputs and output contacts
// ----------------------------------------------------------------
module relay_field_model (
  input wire logic i_clk_sys,
  input wire logic [6:0] i_coil,
  input wire logic [7:0] i_ctype,
  output logic [15:0] o_relay_bits,
  output logic [6:0] o_closed
);
  logic [15:0] field_ff;

  initial begin
    field_ff = 16'h0000;
  end
  assign o_relay_bits = field_ff;
  // Type b closes when dropped, type a when energized
  assign o_closed = i_coil ^ i_ctype[6:0];

  // Field levels change just after an edge, like real inputs
  task automatic drive(input logic [15:0] v);
    @(posedge i_clk_sys);
    field_ff <= v;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import logic_timer_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk_sys, i_sys_rst, i_settings_reset, i_access_lvl2, i_wr, i_rd;
  logic [7:0] i_addr, ctype;
  logic [31:0] i_wdata, o_rdata, rd_val;
  logic [15:0] relay_bits, lv, tmo;
  logic [6:0] coil, closed, model_closed;
  logic alarm_coil, alarm_bit, alarm_closed, irq;
  int err_count, tests_run, cyc;

  logic_timer_output_driver #(.TICK_CYCLES(4), .PULSE_TICKS(2))
    logic_timer_output_driver_i (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_settings_reset(i_settings_reset), .i_relay_bits(relay_bits),
    .i_access_lvl2(i_access_lvl2), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_coil(coil),
    .o_contact_closed(closed), .o_alarm_coil(alarm_coil),
    .o_alarm_bit(alarm_bit), .o_alarm_closed(alarm_closed),
    .o_logic_var(lv), .o_timed_out(tmo), .o_irq(irq));

  relay_field_model relay_field_model_i (
    .i_clk_sys(i_clk_sys), .i_coil(coil), .i_ctype(ctype),
    .o_relay_bits(relay_bits), .o_closed(model_closed));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    // Field jumpers follow the written contact type
    if (a == A_CTYPE) begin
      ctype <= d[7:0];
    end
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rd_val = o_rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n * 4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask

  task automatic give_verdict();
    $display("checks run %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {i_settings_reset, i_access_lvl2, i_wr, i_rd} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    ctype = 8'h00;
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(8'h20); check("pickup0", rd_val, 32'(DFLT_PU));
    rd(8'h30); check("dropout0", rd_val, 32'(DFLT_DO));
    rd(8'h00); check("set0", rd_val, DFLT_SET_MASK);
    rd(8'h42); check("out3", rd_val, 32'(DFLT_OUT_TMR1));
    rd(8'h47); check("unmapped", rd_val, 32'h0000_0000);
    rd(8'h54); check("coil reg", rd_val, 32'h0080_0080);
    check("alarm", {alarm_coil, alarm_bit}, 32'h2);
    check("state", {tmo, lv}, 32'h0000_0000);
    wr(8'h25, 32'hffff_ffff);
    rd(8'h25); check("long sat", rd_val, LONG_MAX_QTR);
    wr(8'h2f, 32'hffff_ffff);
    rd(8'h2f); check("short sat", rd_val, SHORT_MAX_QTR);
    // Default breaker failure timing on the trip bit
    relay_field_model_i.drive(16'h0001);
    ticks(2); check("coil trip", coil[2:0], 32'h1);
    ticks(44); check("tmo0 early", tmo[0], 32'h0);
    ticks(8); check("coil tmr", coil[2:0], 32'h5);
    wr(8'h51, 32'h0000_0084);
    @(negedge i_clk_sys);
    check("closed", closed, model_closed);
    check("alarm closed", alarm_closed, 32'h0);
    relay_field_model_i.drive(16'h0000);
    ticks(4); check("tmo0 hold", tmo[0], 32'h1);
    ticks(8); check("tmo0 drop", coil[2:0], 32'h0);
    check("closed b", closed, model_closed);
    // Constant zero outputs stay dropped
    relay_field_model_i.drive(16'hffff);
    ticks(2); check("unused", coil[6:1], 32'h01);
    relay_field_model_i.drive(16'h0000);
    wr(8'h52, 32'h0000_0008);
    ticks(2); check("pulse out", coil[3], 32'h1);
    ticks(4); check("pulse end", coil[3], 32'h0);
    // Alarm pulse by command and by level 2 entry
    wr(8'h57, 32'h0001_0000);
    wr(8'h52, 32'h0000_0080);
    @(negedge i_clk_sys);
    check("alarm pulse", {alarm_coil, alarm_bit, irq}, 32'h3);
    ticks(4); check("alarm back", {alarm_coil, alarm_bit}, 32'h2);
    rd(8'h55); check("irq st", rd_val[16], 32'h1);
    wr(8'h56, 32'h0001_0000);
    @(negedge i_clk_sys);
    check("irq clr", irq, 32'h0);
    @(posedge i_clk_sys);
    i_access_lvl2 <= 1'b1;
    repeat (2) @(negedge i_clk_sys);
    check("lvl2", {alarm_coil, alarm_bit}, 32'h1);
    ticks(4); check("lvl2 end", {alarm_coil, alarm_bit}, 32'h2);
    @(posedge i_clk_sys);
    i_access_lvl2 <= 1'b0;
    // Sealed failure variable: initiate 4, detectors 5 and 6
    wr(8'h06, 32'h0000_0010);
    wr(8'h16, 32'h0000_0060);
    wr(8'h26, 32'h0000_0004);
    wr(8'h36, 32'h0000_0003);
    wr(8'h50, 32'h0000_0040);
    relay_field_model_i.drive(16'h0030);
    ticks(2);
    relay_field_model_i.drive(16'h0020);
    ticks(2); check("seal", lv[6], 32'h1);
    ticks(4); check("tmo6", tmo[6], 32'h1);
    rd(8'h53); check("state reg", rd_val, 32'h0040_0040);
    relay_field_model_i.drive(16'h0000);
    ticks(2); check("unseal", {lv[6], tmo[6]}, 32'h1);
    ticks(5); check("tmo6 drop", tmo[6], 32'h0);
    relay_field_model_i.drive(16'h0030);
    ticks(2);
    relay_field_model_i.drive(16'h0020);
    ticks(1);
    @(posedge i_clk_sys);
    i_settings_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_settings_reset <= 1'b0;
    @(negedge i_clk_sys);
    check("srst", {tmo, lv}, 32'h0000_0000);
    ticks(3); check("no reseal", lv[6], 32'h0);
    rd(8'h26); check("pu kept", rd_val, 32'h0000_0004);
    // Without the self term the initiate must persist
    wr(8'h50, 32'h0000_0000);
    relay_field_model_i.drive(16'h0030);
    ticks(2);
    relay_field_model_i.drive(16'h0020);
    ticks(2); check("no seal", lv[6], 32'h0);
    ticks(6); check("no timeout", tmo[6], 32'h0);
    give_verdict();
  end
endmodule
